/* inc/sph_defs.svh */
// constants of the privileged command handler: codes, field positions, limits, register map
`ifndef SPH_DEFS_SVH
`define SPH_DEFS_SVH
// command codes
`define SPH_CMD_PHYS_WR 8'h03
`define SPH_CMD_PHYS_RD 8'h04
`define SPH_CMD_MODE 8'h07
`define SPH_CMD_ADV 8'h0F
// function codes, older family mode command
`define SPH_FN_ENT_DL 8'h04
`define SPH_FN_EXIT 8'h05
`define SPH_FN_ENT_UL 8'h06
`define SPH_FN_DT_SIZE 8'h08
// function codes, advanced family command
`define SPH_FN_BIT_WR 8'h02
`define SPH_FN_DL_REQ 8'h05
`define SPH_FN_RESTART 8'h0A
// reply command byte and status values
`define SPH_RPY_BIT 8'h40
`define SPH_RPY_ERR 8'h4F
`define SPH_STS_OK 8'h00
`define SPH_STS_EXT 8'hF0
`define SPH_STS_REJ 8'h10
`define SPH_EXT_DENY 8'h11
`define SPH_EXT_ILL 8'h12
// byte limits: 244 read, 243 written
`define SPH_RD_MAX 8'hF4
`define SPH_WR_MAX 8'hF3
// byte positions inside a command packet
`define SPH_P_SRC 4'h1
`define SPH_P_CMD 4'h2
`define SPH_P_TNS_LO 4'h4
`define SPH_P_TNS_HI 4'h5
`define SPH_P_FNC 4'h6
`define SPH_P_ADR_LO 4'h6
`define SPH_P_ADR_HI 4'h7
`define SPH_P_SIZE 4'h8
`define SPH_P_DATA 8'h08
`define SPH_P_FLAG 4'h7
`define SPH_HDR_LEN 8'h06
`define SPH_HDR_MAX 8'h10
`define SPH_FILE_SHIFT 4'h6
// register byte addresses
`define SPH_A_CTRL 12'h000
`define SPH_A_STAT 12'h004
`define SPH_A_PROG 12'h008
`define SPH_A_CNT 12'h00C
`endif

/* inc/sph_pkg.sv */
// types shared by the privileged command handler
package sph_pkg;
  typedef enum logic [3:0] {
    S_RX = 4'b0001,
    S_EXEC = 4'b0010,
    S_BIT = 4'b0100,
    S_TX = 4'b1000
  } sph_st_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_DL = 2'b01,
    MODE_UL = 2'b10
  } sph_mode_t;

  typedef enum logic [1:0] {
    SRC_HOST = 2'b00,
    SRC_ADV_PEER = 2'b01,
    SRC_OTHER = 2'b10
  } sph_src_t;

  // one byte of a packet with its frame end mark
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } sph_strm_t;

  typedef struct packed {
    sph_st_t st;
    logic [7:0] idx;
    logic [15:0][7:0] hdr;
    sph_src_t kind;
    logic [7:0] wcnt;
    logic wover;
    logic [7:0] ridx;
    logic [7:0] rlen;
    logic [7:0] rcmd;
    logic [7:0] sts;
    logic [7:0] ext;
    logic ext_en;
    logic [15:0] rd_base;
    sph_mode_t mode;
    logic term;
    logic restart;
    logic priv;
    logic [7:0] holder;
    logic [15:0] prog_base;
    logic adv;
    logic [15:0] cmd_cnt;
    logic [15:0] err_cnt;
    logic [1:0] tsync;
    logic cmd_ready;
    sph_strm_t rpy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sph_state_t;
endpackage : sph_pkg

/* hdl/sph_mem.sv */
// byte-wide controller memory, data table then program, held in flip-flops
`timescale 1ns/100ps
module sph_mem #(
  parameter int AW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [7:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [7:0] rd
);
  logic [7:0] mem_q [2**AW];

  // one write port, each entry cleared at reset
  for (genvar i = 0; i < 2**AW; i++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_q[i] <= 8'h00;
      end else if (we && wa == AW'(i)) begin
        mem_q[i] <= wd;
      end
    end
  end

  // read is combinational so a reply byte is ready in the cycle it is picked
  assign rd = mem_q[ra];
endmodule : sph_mem

/* hdl/sph_handler.sv */
// privileged and extended command handler of a network station interface
// How it works
// - enter-upload command puts the older-family processor into upload mode.
// - mode command 07 uses function 06 upload, 04 download.
// - after mode entry terminal port stays disabled until exit or manual select.
// - exit command, function 05, returns processor to run and restarts it.
// - without exit, only a reset or manual select restores terminal communication.
// - physical read returns requested bytes, at most 244 data bytes.
// - physical write stores supplied bytes; at most 243 per command.
// - data table size, function 08, carries twice the word count.
// - data table size is the physical start of program memory.
// - privileged commands are accepted only from a host computer.
// - advanced data commands only from a host or advanced peer.
// - extended status byte appears only when status equals F0.
// - symbol flag byte zero means word symbol, non-zero file symbol.
// - word offset counts from file start; combines with a file symbol.
// - advanced bit write, function 2, changes bits of exactly one word.
// - download request, function 5, grants the download privilege.
// - while one station holds the privilege, others are denied it.
// - advanced error reply uses command byte 4F with status set.
`timescale 1ns/100ps
`include "sph_defs.svh"
module sph_handler import sph_pkg::*; #(
  parameter int AW = 10,
  parameter logic [7:0] OWN_STATION = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sph_strm_t cmd_in,
  input wire sph_src_t cmd_src_kind,
  output logic cmd_ready,
  output sph_strm_t rpy_out,
  input wire logic rpy_ready,
  input wire logic term_mode_sel,
  output sph_mode_t proc_mode,
  output logic proc_restart,
  output logic term_disabled,
  output logic priv_held,
  output logic [15:0] prog_base
);
  sph_state_t r, n;
  logic rej;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [AW-1:0] mem_ra;
  logic [7:0] mem_rd;
  logic [7:0] cmd;
  logic [7:0] function_code;
  logic is_host;
  logic wr_path;
  logic [15:0] wsum;
  logic [15:0] word_adr;
  logic [15:0] bit_adr;
  logic [7:0] set_b;
  logic [7:0] clr_b;
  logic [15:0] rd_adr;

  // packet fields as captured
  assign cmd = r.hdr[`SPH_P_CMD];
  assign function_code = r.hdr[`SPH_P_FNC];
  assign is_host = (r.kind == SRC_HOST);
  // physical write data lands only for a host on an older-family station
  assign wr_path = cmd == `SPH_CMD_PHYS_WR && is_host && !r.adv;
  assign wsum = {r.hdr[`SPH_P_ADR_HI], r.hdr[`SPH_P_ADR_LO]} + {8'h00, r.wcnt};
  // zero flag: word symbol resolved as a word address; else file symbol + offset
  always_comb begin
    if (r.hdr[`SPH_P_FLAG] == 8'h00) begin
      word_adr = {r.hdr[9], r.hdr[8]};
      set_b = r.ridx[0] ? r.hdr[11] : r.hdr[10];
      clr_b = r.ridx[0] ? r.hdr[13] : r.hdr[12];
    end else begin
      word_adr = ({8'h00, r.hdr[8]} << `SPH_FILE_SHIFT) + {r.hdr[10], r.hdr[9]};
      set_b = r.ridx[0] ? r.hdr[12] : r.hdr[11];
      clr_b = r.ridx[0] ? r.hdr[14] : r.hdr[13];
    end
  end
  // the two bytes of the single addressed word, low byte first
  assign bit_adr = {word_adr[14:0], r.ridx[0]};
  assign rd_adr = r.rd_base + {8'h00, r.ridx} - {8'h00, `SPH_HDR_LEN};

  sph_mem #(
    .AW(AW)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .wa(mem_wa),
    .wd(mem_wd),
    .ra(mem_ra),
    .rd(mem_rd)
  );

  // next state of the whole block
  always_comb begin
    n = r;
    rej = 1'b0;
    mem_we = 1'b0;
    mem_wa = wsum[AW-1:0];
    mem_wd = cmd_in.data;
    mem_ra = rd_adr[AW-1:0];
    n.restart = 1'b0;
    // terminal select pin: second stage only is looked at
    n.tsync = {r.tsync[0], term_mode_sel};
    if (r.tsync[1]) begin
      n.term = 1'b0;
    end
    // apb slave: one wait state, answer registered
    n.pready = psel & penable & ~r.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel & penable & ~r.pready) begin
      case (paddr)
        `SPH_A_CTRL: n.prdata = {31'h0000_0000, r.adv};
        `SPH_A_STAT: n.prdata = {16'h0000, r.holder, 3'h0, r.priv, r.term, 1'b0, r.mode};
        `SPH_A_PROG: n.prdata = {16'h0000, r.prog_base};
        `SPH_A_CNT: n.prdata = {r.err_cnt, r.cmd_cnt};
        default: n.pslverr = 1'b1;
      endcase
    end
    // writes take effect at the edge that completes the access
    if (psel & penable & r.pready & pwrite && paddr == `SPH_A_CTRL) begin
      n.adv = pwdata[0];
    end
    unique case (r.st)
      S_RX: begin
        n.cmd_ready = 1'b1;
        if (cmd_in.valid & r.cmd_ready) begin
          if (r.idx < `SPH_HDR_MAX) begin
            n.hdr[r.idx[3:0]] = cmd_in.data;
          end
          if (r.idx == 8'h00) begin
            n.kind = cmd_src_kind;
            n.wcnt = 8'h00;
            n.wover = 1'b0;
          end
          if (r.idx != 8'hFF) begin
            n.idx = r.idx + 8'h01;
          end
          // write data streams into memory; excess bytes are dropped
          if (wr_path && r.idx >= `SPH_P_DATA) begin
            if (r.wcnt < `SPH_WR_MAX) begin
              mem_we = 1'b1;
              n.wcnt = r.wcnt + 8'h01;
            end else begin
              n.wover = 1'b1;
            end
          end
          if (cmd_in.last) begin
            n.st = S_EXEC;
            n.cmd_ready = 1'b0;
          end
        end
      end
      S_EXEC: begin
        n.cmd_cnt = r.cmd_cnt + 16'h0001;
        n.idx = 8'h00;
        n.ridx = 8'h00;
        n.rlen = `SPH_HDR_LEN;
        n.sts = `SPH_STS_OK;
        n.ext_en = 1'b0;
        // set only here so a deny code survives until its reply byte goes out
        n.ext = `SPH_EXT_ILL;
        n.rcmd = cmd | `SPH_RPY_BIT;
        n.st = S_TX;
        unique case (cmd)
          `SPH_CMD_MODE: begin
            if (r.adv || !is_host) begin
              rej = 1'b1;
            end else begin
              unique case (function_code)
                `SPH_FN_ENT_DL: begin
                  n.mode = MODE_DL;
                  n.term = 1'b1;
                end
                `SPH_FN_ENT_UL: begin
                  n.mode = MODE_UL;
                  n.term = 1'b1;
                end
                `SPH_FN_EXIT: begin
                  n.mode = MODE_RUN;
                  n.term = 1'b0;
                  n.restart = 1'b1;
                end
                `SPH_FN_DT_SIZE: begin
                  // byte count doubles as program start address
                  n.prog_base = {r.hdr[8], r.hdr[7]};
                end
                default: rej = 1'b1;
              endcase
            end
          end
          `SPH_CMD_PHYS_RD: begin
            if (r.adv || !is_host || r.hdr[`SPH_P_SIZE] > `SPH_RD_MAX) begin
              rej = 1'b1;
            end else begin
              n.rlen = `SPH_HDR_LEN + r.hdr[`SPH_P_SIZE];
              n.rd_base = {r.hdr[`SPH_P_ADR_HI], r.hdr[`SPH_P_ADR_LO]};
            end
          end
          `SPH_CMD_PHYS_WR: begin
            rej = !wr_path || r.wover;
          end
          `SPH_CMD_ADV: begin
            if (!r.adv) begin
              rej = 1'b1;
            end else begin
              unique case (function_code)
                `SPH_FN_DL_REQ: begin
                  if (!is_host) begin
                    rej = 1'b1;
                  end else if (r.priv && r.holder != r.hdr[`SPH_P_SRC]) begin
                    rej = 1'b1;
                    n.ext = `SPH_EXT_DENY;
                  end else begin
                    n.priv = 1'b1;
                    n.holder = r.hdr[`SPH_P_SRC];
                  end
                end
                `SPH_FN_RESTART: begin
                  if (is_host && r.priv && r.holder == r.hdr[`SPH_P_SRC]) begin
                    n.priv = 1'b0;
                    n.restart = 1'b1;
                  end else begin
                    rej = 1'b1;
                  end
                end
                `SPH_FN_BIT_WR: begin
                  if (r.kind == SRC_OTHER) begin
                    rej = 1'b1;
                  end else begin
                    n.st = S_BIT;
                  end
                end
                default: rej = 1'b1;
              endcase
            end
          end
          default: rej = 1'b1;
        endcase
        // refusal: advanced family uses 4F, F0 and an extended code
        if (rej) begin
          n.err_cnt = r.err_cnt + 16'h0001;
          n.st = S_TX;
          n.sts = r.adv ? `SPH_STS_EXT : `SPH_STS_REJ;
          n.ext_en = r.adv;
          n.rlen = r.adv ? `SPH_HDR_LEN + 8'h01 : `SPH_HDR_LEN;
          if (r.adv) begin
            n.rcmd = `SPH_RPY_ERR;
          end
        end
      end
      S_BIT: begin
        // read-modify-write of one byte a cycle; clear wins over set
        mem_ra = bit_adr[AW-1:0];
        mem_wa = bit_adr[AW-1:0];
        mem_wd = (mem_rd | set_b) & ~clr_b;
        mem_we = 1'b1;
        n.ridx = r.ridx + 8'h01;
        if (r.ridx[0]) begin
          n.ridx = 8'h00;
          n.st = S_TX;
        end
      end
      S_TX: begin
        // registered reply byte; advances only when the sink takes it
        if (!r.rpy.valid || rpy_ready) begin
          if (r.ridx < r.rlen) begin
            n.rpy.valid = 1'b1;
            n.rpy.last = (r.ridx == r.rlen - 8'h01);
            n.ridx = r.ridx + 8'h01;
            unique case (r.ridx)
              8'h00: n.rpy.data = r.hdr[`SPH_P_SRC];
              8'h01: n.rpy.data = OWN_STATION;
              8'h02: n.rpy.data = r.rcmd;
              8'h03: n.rpy.data = r.sts;
              8'h04: n.rpy.data = r.hdr[`SPH_P_TNS_LO];
              8'h05: n.rpy.data = r.hdr[`SPH_P_TNS_HI];
              default: n.rpy.data = r.ext_en ? r.ext : mem_rd;
            endcase
          end else begin
            n.rpy = '0;
            n.st = S_RX;
            n.cmd_ready = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= S_RX;
      r.mode <= MODE_RUN;
      r.kind <= SRC_HOST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign cmd_ready = r.cmd_ready;
  assign rpy_out = r.rpy;
  assign proc_mode = r.mode;
  assign proc_restart = r.restart;
  assign term_disabled = r.term;
  assign priv_held = r.priv;
  assign prog_base = r.prog_base;

  // checks on the command sequences
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mode_cmd(logic [7:0] f);
    r.st == S_EXEC && cmd == `SPH_CMD_MODE && function_code == f && !rej;
  endsequence

  a_upload_entry: assert property (s_mode_cmd(`SPH_FN_ENT_UL) |=> proc_mode == MODE_UL)
    else $error("upload mode not entered");
  a_term_held: assert property (s_mode_cmd(`SPH_FN_ENT_DL) |=> term_disabled [*2])
    else $error("terminal not held disabled");
  a_exit_restart: assert property (s_mode_cmd(`SPH_FN_EXIT)
    |=> proc_restart && proc_mode == MODE_RUN ##1 !proc_restart)
    else $error("exit did not restart once");
  a_read_bound: assert property (r.rlen <= `SPH_HDR_LEN + `SPH_RD_MAX)
    else $error("reply longer than read limit");
  a_write_bound: assert property (mem_we && r.st == S_RX |-> r.wcnt < `SPH_WR_MAX)
    else $error("write beyond byte limit");
  a_ext_only_f0: assert property (r.st == S_TX && r.ext_en |-> r.sts == `SPH_STS_EXT)
    else $error("extended status without F0");
  a_priv_deny: assert property (r.st == S_EXEC && cmd == `SPH_CMD_ADV && r.adv
    && function_code == `SPH_FN_DL_REQ && r.priv && r.holder != r.hdr[`SPH_P_SRC]
    |=> r.sts != `SPH_STS_OK && $stable(r.holder))
    else $error("privilege not denied");
  a_err_cmd_byte: assert property (r.st == S_EXEC && rej && r.adv
    |=> r.rcmd == `SPH_RPY_ERR && r.sts != `SPH_STS_OK)
    else $error("advanced error reply malformed");
  a_reply_bit6: assert property (r.st == S_EXEC && !rej |=> r.rcmd == (cmd | `SPH_RPY_BIT))
    else $error("reply command bit 6 missing");
  a_host_only: assert property (r.st == S_EXEC && cmd == `SPH_CMD_MODE && !is_host
    |=> r.sts != `SPH_STS_OK && $stable(proc_mode))
    else $error("privileged command from non-host taken");
endmodule : sph_handler

/* tb/sph_station.sv */
// far-side station model: sends command frames, takes reply bytes with stalls
`timescale 1ns/100ps
module sph_station import sph_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_ready,
  input wire sph_strm_t rpy_out,
  output sph_strm_t cmd_in,
  output sph_src_t cmd_src_kind,
  output logic rpy_ready
);
  logic [7:0] rq[$];
  int n_last;
  initial begin
    cmd_in = '0;
    cmd_src_kind = SRC_OTHER;
    rpy_ready = 1'b0;
    n_last = 0;
  end
  // reply sink; stalls about one cycle in four so held bytes are exercised
  always @(posedge pclk) begin
    if (rpy_out.valid === 1'b1 && rpy_ready) begin
      rq.push_back(rpy_out.data);
      if (rpy_out.last) n_last++;
    end
    rpy_ready <= ($urandom % 4) != 0;
  end
  // one frame; each byte held until cmd_ready is seen at an edge
  task automatic send(input logic [7:0] b[$], input sph_src_t k, output bit ok);
    int t;
    ok = 1'b1;
    foreach (b[i]) begin
      cmd_in <= '{valid: 1'b1, data: b[i], last: i == b.size() - 1};
      cmd_src_kind <= k;
      t = 0;
      do begin
        @(posedge pclk);
        t++;
      end while (cmd_ready !== 1'b1 && t < 100);
      if (cmd_ready !== 1'b1) ok = 1'b0;
    end
    // released lines show no stale value
    cmd_in <= '{valid: 1'b0, data: ~b[b.size() - 1], last: 1'b0};
    cmd_src_kind <= sph_src_t'(~k);
  endtask : send
endmodule : sph_station

/* tb/station_privileged_command_handler_tb.sv */
// self-checking bench: apb master, command frames and a reference model
`timescale 1ns/100ps
module station_privileged_command_handler_tb import sph_pkg::*;;
  typedef logic [7:0] sph_q8_t[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_ready, rpy_ready, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  sph_strm_t cmd_in, rpy_out;
  sph_src_t cmd_src_kind;
  logic term_mode_sel, proc_restart, term_disabled, priv_held;
  sph_mode_t proc_mode;
  logic [15:0] prog_base;
  int n_fail, checks_done, n_rst, m_mode, m_term, m_priv, m_hold, m_prog, m_rst, m_adv, m_cmd, m_err;
  logic [7:0] mem[1024];

  sph_handler dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_in(cmd_in), .cmd_src_kind(cmd_src_kind), .cmd_ready(cmd_ready),
    .rpy_out(rpy_out), .rpy_ready(rpy_ready), .term_mode_sel(term_mode_sel),
    .proc_mode(proc_mode), .proc_restart(proc_restart), .term_disabled(term_disabled),
    .priv_held(priv_held), .prog_base(prog_base));
  sph_station sta_u (.pclk(pclk), .presetn(presetn), .cmd_ready(cmd_ready), .rpy_out(rpy_out),
    .cmd_in(cmd_in), .cmd_src_kind(cmd_src_kind), .rpy_ready(rpy_ready));

  // clock and restart pulse counter
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (proc_restart === 1'b1) n_rst++;

  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // one apb transfer; waits for pready, gives up after a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin n_fail++; results(); end
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, 1'b0);
  endtask : rdchk

  task automatic rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    {m_mode, m_term, m_priv, m_hold, m_prog, m_adv, m_cmd, m_err} = '0;
    foreach (mem[i]) mem[i] = 8'h00;
  endtask : rst

  function automatic sph_q8_t rnd(input sph_q8_t p, input int n);
    repeat (n) p.push_back(8'($urandom));
    return p;
  endfunction : rnd

  // reference model: expected reply and state change of one command
  function automatic sph_q8_t predict(input sph_q8_t c, input sph_src_t k);
    int cmd, fn, sts, a, n, w, v, ex;
    sph_q8_t r, d;
    cmd = c[2]; fn = c[6]; sts = 0; a = {c[7], c[6]}; n = c.size() - 8; ex = 8'h12;
    if (cmd != 8'h0F && (k != SRC_HOST || m_adv)) sts = 8'h10;
    else if (cmd == 8'h0F && (k == SRC_OTHER || !m_adv)) sts = 8'h10;
    else if (cmd == 8'h07) begin
      if (fn == 4) begin m_mode = 1; m_term = 1; end
      if (fn == 6) begin m_mode = 2; m_term = 1; end
      if (fn == 5) begin m_mode = 0; m_term = 0; m_rst++; end
      if (fn == 8) m_prog = {c[8], c[7]};
    end else if (cmd == 8'h04) begin
      if (c[8] > 244) sts = 8'h10;
      else for (int i = 0; i < c[8]; i++) d.push_back(mem[a + i]);
    end else if (cmd == 8'h03) begin
      for (int i = 0; i < n && i < 243; i++) mem[a + i] = c[8 + i];
      if (n > 243) sts = 8'h10;
    end else if (fn == 5) begin
      if (k != SRC_HOST) sts = 8'h10;
      else if (m_priv && m_hold != c[1]) begin sts = 8'hF0; ex = 8'h11; end
      else begin m_priv = 1; m_hold = c[1]; end
    end else if (fn == 8'h0A) begin
      if (k != SRC_HOST || !m_priv || m_hold != c[1]) sts = 8'h10;
      else begin m_priv = 0; m_rst++; end
    end
    else if (fn == 2) begin
      w = c[7] ? c[8] * 64 + {c[10], c[9]} : {c[9], c[8]};
      v = c[7] ? 11 : 10;
      mem[2 * w] = (mem[2 * w] | c[v]) & ~c[v + 2];
      mem[2 * w + 1] = (mem[2 * w + 1] | c[v + 1]) & ~c[v + 3];
    end
    m_cmd++;
    if (sts != 0) m_err++;
    // an advanced-family station refuses with F0 and the 4F reply byte
    if (sts != 0 && m_adv) sts = 8'hF0;
    r = {c[1], 8'h01, sts == 8'hF0 ? 8'h4F : c[2] | 8'h40, 8'(sts), c[4], c[5]};
    if (sts == 8'hF0) r.push_back(8'(ex));
    return {r, d};
  endfunction : predict

  // send one frame, wait for the whole reply, compare it and the state pins
  task automatic xact(input logic [7:0] src, cmd, input sph_q8_t b, input sph_src_t k);
    sph_q8_t c, x;
    bit ok;
    int t, nl;
    // single-packet frames only: offset zero, word total is the frame's own
    c = {8'h01, src, cmd, 8'h00, 8'($urandom), 8'($urandom), b};
    x = predict(c, k);
    sta_u.rq = {};
    nl = sta_u.n_last;
    sta_u.send(c, k, ok);
    t = 0;
    while (sta_u.n_last == nl && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    if (!ok || sta_u.n_last == nl) begin n_fail++; results(); end
    repeat (2) @(posedge pclk);
    chk(sta_u.rq.size(), x.size());
    foreach (x[i]) chk(sta_u.rq[i], x[i]);
    chk(proc_mode, m_mode);
    chk(term_disabled, m_term);
    chk(priv_held, m_priv);
    chk(prog_base, m_prog);
    chk(n_rst, m_rst);
  endtask : xact

  // main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; term_mode_sel = 1'b0;
    n_fail = 0; checks_done = 0; n_rst = 0; m_rst = 0;
    void'($urandom(32'hE3CCC0E5));
    rst();
    rdchk(12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    xact(8'h20, 8'h07, '{8'h06}, SRC_HOST);
    xact(8'h20, 8'h07, '{8'h08, 8'h80, 8'h01}, SRC_HOST);
    rdchk(12'h008, 32'h0180);
    xact(8'h20, 8'h03, rnd('{8'h10, 8'h00}, 16), SRC_HOST);
    xact(8'h20, 8'h04, '{8'h10, 8'h00, 8'h10}, SRC_HOST);
    xact(8'h20, 8'h03, rnd('{8'h00, 8'h01}, 244), SRC_HOST);
    xact(8'h20, 8'h04, '{8'h00, 8'h01, 8'hF4}, SRC_HOST);
    xact(8'h20, 8'h04, '{8'h00, 8'h00, 8'hF5}, SRC_HOST);
    xact(8'h40, 8'h04, '{8'h10, 8'h00, 8'h02}, SRC_ADV_PEER);
    xact(8'h40, 8'h07, '{8'h06}, SRC_ADV_PEER);
    xact(8'h20, 8'h07, '{8'h05}, SRC_HOST);
    xact(8'h20, 8'h07, '{8'h04}, SRC_HOST);
    // manual select at the terminal leaves the mode-select state
    term_mode_sel <= 1'b1;
    repeat (4) @(posedge pclk);
    term_mode_sel <= 1'b0;
    repeat (3) @(posedge pclk);
    m_term = 0;
    chk(term_disabled, 1'b0);
    xact(8'h20, 8'h07, '{8'h06}, SRC_HOST);
    repeat (20) @(posedge pclk);
    chk(term_disabled, 1'b1);
    rdchk(12'h004, m_mode | (m_term << 3) | (m_priv << 4) | (m_hold << 8));
    rdchk(12'h00C, {m_err[15:0], m_cmd[15:0]});
    rst();
    chk(term_disabled, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    m_adv = 1;
    xact(8'h20, 8'h0F, '{8'h05}, SRC_HOST);
    xact(8'h30, 8'h0F, '{8'h05}, SRC_HOST);
    rdchk(12'h004, m_mode | (m_term << 3) | (m_priv << 4) | (m_hold << 8));
    xact(8'h40, 8'h0F, '{8'h02, 8'h00, 8'h08, 8'h00, 8'hF0, 8'h0F, 8'h30, 8'h03},
      SRC_ADV_PEER);
    xact(8'h20, 8'h0F, '{8'h02, 8'h01, 8'h02, 8'h05, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'hF0},
      SRC_HOST);
    xact(8'h50, 8'h0F, '{8'h02, 8'h00, 8'h08, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00},
      SRC_OTHER);
    xact(8'h20, 8'h07, '{8'h05}, SRC_HOST);
    xact(8'h20, 8'h0F, '{8'h0A}, SRC_HOST);
    apb(1'b1, 12'h000, 32'h0);
    m_adv = 0;
    xact(8'h20, 8'h04, '{8'h0E, 8'h00, 8'h06}, SRC_HOST);
    xact(8'h20, 8'h04, '{8'h08, 8'h01, 8'h06}, SRC_HOST);
    rdchk(12'h00C, {m_err[15:0], m_cmd[15:0]});
    results();
  end
endmodule : station_privileged_command_handler_tb
